// file: hw/vpcs_dev.sv
// device end: command decoder, phrase sequencer, user area transfer
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module vpcs_dev #(
	parameter int STEP_DIV0 = vpcs_pkg::STEP_DIV0,
	parameter int STEP_DIV1 = vpcs_pkg::STEP_DIV1,
	parameter int STEP_DIV2 = vpcs_pkg::STEP_DIV2,
	parameter int STEP_DIV3 = vpcs_pkg::STEP_DIV3
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	vpcs_if.dev bus,
	input wire logic i_voice,
	input wire logic i_rom_valid,
	input wire logic [vpcs_pkg::ROMREC_W-1:0] i_rom_rec,
	output logic o_rom_req,
	output logic [7:0] o_rom_phrase,
	output logic [19:0] o_mem_addr,
	output logic o_mem_step,
	output logic o_capture,
	output logic o_width4,
	output logic [1:0] o_volume
);
	localparam int BW = $clog2(vpcs_pkg::BUSY_CYC + 1);
	localparam int DW = 13;

	if (STEP_DIV0 < 2 || STEP_DIV0 > 2**DW || STEP_DIV1 < 2 ||
		STEP_DIV1 > 2**DW || STEP_DIV2 < 2 || STEP_DIV2 > 2**DW ||
		STEP_DIV3 < 2 || STEP_DIV3 > 2**DW) begin : g_chk
		$error("vpcs_dev: step divisor out of range");
	end

	typedef enum logic [2:0] {
		S_IDLE, S_FETCH, S_ROMF, S_TRIG, S_RUN, S_HOLD, S_XFER
	} vpcs_state_t;

	vpcs_state_t state_r;
	logic [BW-1:0] busy_r;
	logic [3:0] op_r;
	logic [3:0] pend_r;
	logic [31:0] par_r;
	logic [1:0] set_r;
	logic [1:0] fs_r;
	logic [1:0] thr_r;
	logic [7:0] phrase_r;
	logic [19:0] cnt_r;
	logic [19:0] stop_r;
	logic [DW-1:0] div_r;
	logic [DW-1:0] div_ld;
	logic next_r;
	logic q_v_r;
	logic [7:0] q_ph_r;
	logic [7:0] ptr_r;
	logic mixed_r;
	logic [3:0] dd_r;
	logic dd_oe_r;
	logic busy;
	logic take_wr;
	logic take_rd;
	logic exec;
	logic [3:0] xop;
	logic [31:0] xpar;
	logic [3:0] stat;
	logic tick;
	logic at_end;
	logic dwr;
	logic drd;
	logic idx_we;
	logic [31:0] idx_rd;
	logic [3:0] usr_rd;

	assign bus.dd = dd_r;
	assign bus.dd_oe = dd_oe_r;

	////////////////////////////////////////////////////////////////////
	// strobe acceptance and command decode
	assign busy = (busy_r != '0) || state_r == S_FETCH ||
		state_r == S_ROMF;
	assign take_wr = i_ce && bus.wr && !busy;
	assign take_rd = i_ce && bus.rd;
	assign dwr = take_wr && !bus.sel && state_r == S_XFER && o_capture;
	assign drd = take_rd && !bus.sel && state_r == S_XFER && mixed_r &&
		!busy;
	assign tick = state_r == S_RUN && div_r == '0;
	assign at_end = cnt_r == stop_r;

	always_comb begin
		exec = 1'b0;
		xop = op_r;
		xpar = {par_r[27:0], bus.hd};
		if (take_wr && bus.sel) begin
			if (pend_r == 4'h0) begin
				xop = bus.hd;
				exec = vpcs_pkg::vpcs_nparam(bus.hd) == 4'h0;
			end else begin
				exec = pend_r == 4'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			op_r <= '0;
			pend_r <= '0;
			par_r <= '0;
		end else if (take_wr && bus.sel) begin
			if (pend_r == 4'h0) begin
				op_r <= bus.hd;
				pend_r <= vpcs_pkg::vpcs_nparam(bus.hd);
				par_r <= '0;
			end else begin
				pend_r <= pend_r - 4'h1;
				par_r <= xpar;
			end
		end
	end

	// each accepted nibble holds busy for the fixed interval
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_r <= '0;
		end else if (take_wr || drd) begin
			busy_r <= BW'(vpcs_pkg::BUSY_CYC);
		end else if (i_ce && busy_r != '0) begin
			busy_r <= busy_r - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// playback conditions
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			set_r <= vpcs_pkg::RST_SET;
			fs_r <= '0;
			thr_r <= '0;
			o_width4 <= 1'b0;
			o_volume <= vpcs_pkg::RST_VOL;
			o_capture <= 1'b0;
			phrase_r <= '0;
		end else if (i_ce) begin
			if (state_r == S_ROMF && i_rom_valid) begin
				fs_r <= i_rom_rec[vpcs_pkg::RR_FS_LSB+:2];
				o_width4 <= i_rom_rec[vpcs_pkg::RR_W_BIT];
			end
			if (exec) begin
				unique case (xop)
					vpcs_pkg::OP_CODING: begin
						// threshold only matters when capturing
						o_width4 <= xpar[0];
						thr_r <= xpar[2:1];
					end
					vpcs_pkg::OP_RATE: begin
						set_r <= xpar[1:0];
						if (xpar[1:0] != vpcs_pkg::SET_ROMCODE) begin
							fs_r <= xpar[3:2];
						end
					end
					vpcs_pkg::OP_PHRASE: begin
						if (set_r == vpcs_pkg::SET_ROMCODE) begin
							phrase_r <= xpar[7:0];
						end else begin
							phrase_r <= {2'b00, xpar[5:0]};
						end
					end
					vpcs_pkg::OP_VOLUME: o_volume <= xpar[1:0];
					vpcs_pkg::OP_CAPTURE: o_capture <= 1'b1;
					vpcs_pkg::OP_PLAY: o_capture <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequencer state
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= S_IDLE;
			q_v_r <= 1'b0;
			q_ph_r <= '0;
			o_rom_req <= 1'b0;
			o_rom_phrase <= '0;
		end else if (i_ce) begin
			o_rom_req <= 1'b0;
			unique case (state_r)
				S_IDLE: begin
					q_v_r <= 1'b0;
					if (exec && xop == vpcs_pkg::OP_START) begin
						if (set_r == vpcs_pkg::SET_ROMCODE) begin
							state_r <= S_ROMF;
							o_rom_req <= 1'b1;
							o_rom_phrase <= phrase_r;
						end else begin
							state_r <= S_FETCH;
						end
					end else if (exec && xop == vpcs_pkg::OP_XFER &&
						!set_r[1]) begin
						state_r <= S_XFER;
					end
				end
				S_FETCH: begin
					if (o_capture && thr_r != 2'h0) begin
						state_r <= S_TRIG;
					end else begin
						state_r <= S_RUN;
					end
				end
				S_ROMF: if (i_rom_valid) state_r <= S_RUN;
				S_TRIG: begin
					if (exec && xop == vpcs_pkg::OP_STOP) begin
						state_r <= S_IDLE;
					end else if (i_voice) begin
						state_r <= S_RUN;
					end
				end
				S_RUN: begin
					if (exec && xop == vpcs_pkg::OP_STOP) begin
						state_r <= S_IDLE;
					end else if (exec && xop == vpcs_pkg::OP_PAUSE) begin
						state_r <= S_HOLD;
					end else if (tick && at_end) begin
						if (q_v_r) begin
							state_r <= S_ROMF;
							o_rom_req <= 1'b1;
							o_rom_phrase <= q_ph_r;
							q_v_r <= 1'b0;
						end else begin
							state_r <= S_IDLE;
						end
					end else if (exec && xop == vpcs_pkg::OP_START &&
						set_r == vpcs_pkg::SET_ROMCODE && !o_capture) begin
						q_v_r <= 1'b1;
						q_ph_r <= phrase_r;
					end
				end
				S_HOLD: begin
					if (exec && xop == vpcs_pkg::OP_START) begin
						state_r <= S_RUN;
					end else if (exec && xop == vpcs_pkg::OP_STOP) begin
						state_r <= S_IDLE;
					end
				end
				S_XFER: begin
					if (exec && xop == vpcs_pkg::OP_STOP) begin
						state_r <= S_IDLE;
					end
				end
			endcase
		end
	end

	// next-phrase-open: rising on a fetched ROM phrase wins over clears
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			next_r <= 1'b0;
		end else if (i_ce) begin
			if (state_r == S_ROMF && i_rom_valid) begin
				next_r <= 1'b1;
			end else if (exec && xop == vpcs_pkg::OP_START &&
				set_r == vpcs_pkg::SET_ROMCODE) begin
				next_r <= 1'b0;
			end else if (state_r == S_IDLE) begin
				next_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// address counter and sample pacing
	always_comb begin
		unique case (fs_r)
			2'h0: div_ld = DW'(STEP_DIV0 - 1);
			2'h1: div_ld = DW'(STEP_DIV1 - 1);
			2'h2: div_ld = DW'(STEP_DIV2 - 1);
			2'h3: div_ld = DW'(STEP_DIV3 - 1);
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_r <= '0;
			stop_r <= '0;
			div_r <= '0;
			o_mem_addr <= '0;
			o_mem_step <= 1'b0;
		end else if (i_ce) begin
			o_mem_step <= 1'b0;
			div_r <= (tick || state_r != S_RUN) ? div_ld : div_r - 1'b1;
			if (state_r == S_FETCH) begin
				cnt_r <= {idx_rd[vpcs_pkg::IX_SX_LSB+:12], 8'h00};
				stop_r <= idx_rd[vpcs_pkg::IX_STOP_LSB+:20];
			end else if (state_r == S_ROMF && i_rom_valid) begin
				cnt_r <= {i_rom_rec[vpcs_pkg::RR_SX_LSB+:12], 8'h00};
				stop_r <= i_rom_rec[vpcs_pkg::RR_STOP_LSB+:20];
			end else if (tick && !at_end) begin
				o_mem_addr <= cnt_r;
				o_mem_step <= 1'b1;
				cnt_r <= cnt_r + 20'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// index and user areas
	assign idx_we = exec && state_r == S_IDLE &&
		(xop == vpcs_pkg::OP_ADDR || xop == vpcs_pkg::OP_ERASE);

	vpcs_mem #(.W(32), .AW(6)) u_idx (
		.i_clk(i_clk),
		.i_ce(i_ce),
		.i_we(idx_we),
		.i_addr(phrase_r[5:0]),
		.i_wd(xop == vpcs_pkg::OP_ADDR ? xpar : 32'h0000_0000),
		.o_rd(idx_rd)
	);

	vpcs_mem #(.W(4), .AW(14)) u_usr (
		.i_clk(i_clk),
		.i_ce(i_ce),
		.i_we(dwr),
		.i_addr({phrase_r[5:0], ptr_r}),
		.i_wd(bus.hd),
		.o_rd(usr_rd)
	);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ptr_r <= '0;
			mixed_r <= 1'b0;
		end else if (exec && xop == vpcs_pkg::OP_XFER) begin
			ptr_r <= '0;
			mixed_r <= 1'b0;
		end else if (state_r == S_XFER) begin
			if (exec && xop == vpcs_pkg::OP_PLAY) begin
				mixed_r <= 1'b1;
			end
			if (dwr || drd) begin
				ptr_r <= ptr_r + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read answers, one cycle after the strobe
	always_comb begin
		stat = '0;
		stat[vpcs_pkg::ST_ACTIVE] = state_r != S_IDLE && state_r != S_XFER;
		stat[vpcs_pkg::ST_NEXT] = next_r;
		stat[vpcs_pkg::ST_PAUSED] = state_r == S_HOLD;
		stat[vpcs_pkg::ST_BUSY] = busy;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			dd_r <= '0;
			dd_oe_r <= 1'b0;
		end else if (i_ce) begin
			dd_oe_r <= bus.rd;
			if (take_rd) begin
				if (!bus.sel && state_r == S_XFER && mixed_r) begin
					dd_r <= usr_rd;
				end else begin
					dd_r <= stat;
				end
			end
		end
	end
endmodule

// file: hw/vpcs_pkg.sv
// shared constants, encodings and timing of the phrase sequencer link
// Behaviour
// - direct playback uses set 2, phrases 00h-3Fh
// - start loads counter and stop from index
// - playback ends when counter reaches stop
// - host waits active clear after stop
// - playback ignores trigger threshold, keeps width
// - set 1: fs ignored, phrases 01h-FFh; the code also accepts phrase 00h
// - set 1 start fetches record from ROM
// - accepted ROM start clears next-open flag
// - next-open rises when next phrase may queue
// - set 3 plays host-loaded index addresses
// - host sends 32 address bits per phrase
// - no phrase 00h in flex recording
// - pause holds paused and active high
// - resumed triggered recording starts at once
// - pause ignored in standby, pause, trigger wait
// - stop while paused returns to standby
// - host keeps transfers within phrase capacity
// - transfer needs set 0 or 1
// - host waits busy between data writes
// - write-only session data reads report status
// - play then read strobes give nibbles
// - host waits busy after transfer stop
package vpcs_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int BUSY_NS = 2000;
	localparam int BUSY_CYC = (BUSY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int FS_HZ0 = 4000;
	localparam int FS_HZ1 = 5000;
	localparam int FS_HZ2 = 6000;
	localparam int FS_HZ3 = 8000;
	localparam int STEP_DIV0 = CLK_HZ / FS_HZ0;
	localparam int STEP_DIV1 = CLK_HZ / FS_HZ1;
	localparam int STEP_DIV2 = CLK_HZ / FS_HZ2;
	localparam int STEP_DIV3 = CLK_HZ / FS_HZ3;

	localparam logic [3:0] OP_CODING = 4'h1;
	localparam logic [3:0] OP_RATE = 4'h2;
	localparam logic [3:0] OP_PHRASE = 4'h3;
	localparam logic [3:0] OP_VOLUME = 4'h4;
	localparam logic [3:0] OP_CAPTURE = 4'h5;
	localparam logic [3:0] OP_PLAY = 4'h6;
	localparam logic [3:0] OP_ADDR = 4'h7;
	localparam logic [3:0] OP_XFER = 4'h8;
	localparam logic [3:0] OP_ERASE = 4'h9;
	localparam logic [3:0] OP_START = 4'hA;
	localparam logic [3:0] OP_STOP = 4'hB;
	localparam logic [3:0] OP_PAUSE = 4'hC;

	localparam logic [1:0] SET_FLEX = 2'h0;
	localparam logic [1:0] SET_ROMCODE = 2'h1;
	localparam logic [1:0] SET_DIRECT = 2'h2;
	localparam logic [1:0] SET_DROM = 2'h3;

	// status nibble bit positions
	localparam int ST_ACTIVE = 0;
	localparam int ST_NEXT = 1;
	localparam int ST_PAUSED = 2;
	localparam int ST_BUSY = 3;

	// index record {start_x, end_x, end_y}
	localparam int IX_SX_LSB = 20;
	localparam int IX_STOP_LSB = 0;
	// rom record {start_x, end_x, end_y, fs, width}
	localparam int ROMREC_W = 35;
	localparam int RR_SX_LSB = 23;
	localparam int RR_STOP_LSB = 3;
	localparam int RR_FS_LSB = 1;
	localparam int RR_W_BIT = 0;

	localparam logic [7:0] USR_FLEX_NIB = 8'hB0;
	localparam logic [7:0] USR_DIRECT_NIB = 8'hF0;

	localparam logic [4:0] HR_CMD = 5'h00;
	localparam logic [4:0] HR_PARAM = 5'h04;
	localparam logic [4:0] HR_DATA = 5'h08;
	localparam logic [4:0] HR_STAT = 5'h0C;
	localparam logic [4:0] HR_CFG = 5'h10;
	localparam int HD_READ_BIT = 8;

	localparam logic [1:0] RST_SET = 2'h0;
	localparam logic [1:0] RST_VOL = 2'h0;

	function automatic logic [3:0] vpcs_nparam(logic [3:0] op);
		unique case (op)
			OP_CODING, OP_RATE, OP_VOLUME: return 4'h1;
			OP_PHRASE: return 4'h2;
			OP_ADDR: return 4'h8;
			default: return 4'h0;
		endcase
	endfunction
endpackage

// file: hw/vpcs_if.sv
// nibble bus between host controller and phrase sequencer device
`timescale 1ns/1ps
interface vpcs_if;
	logic wr;
	logic rd;
	logic sel;
	logic [3:0] hd;
	logic hd_oe;
	logic [3:0] dd;
	logic dd_oe;
	modport dev (input wr, rd, sel, hd, hd_oe, output dd, dd_oe);
	modport host (output wr, rd, sel, hd, hd_oe, input dd, dd_oe);
endinterface

// file: hw/vpcs_mem.sv
// single-port synchronous memory for index and user areas
`timescale 1ns/1ps
module vpcs_mem #(
	parameter int W = 4,
	parameter int AW = 6
) (
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_we,
	input wire logic [AW-1:0] i_addr,
	input wire logic [W-1:0] i_wd,
	output logic [W-1:0] o_rd
);
	logic [W-1:0] mem [2**AW];

	if (W < 1 || AW < 1) begin : g_chk
		$error("vpcs_mem: bad geometry");
	end

	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			if (i_we) begin
				mem[i_addr] <= i_wd;
			end
			o_rd <= mem[i_addr];
		end
	end
endmodule

// file: hw/vpcs_host.sv
// host end: sends software commands as nibbles and polls busy
`timescale 1ns/1ps
module vpcs_host (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	vpcs_if.host bus,
	input wire logic [4:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata
);
	typedef enum logic [2:0] {
		H_IDLE, H_SEND, H_POLL, H_GAP, H_LOOK, H_DRD
	} vpcs_hstate_t;

	vpcs_hstate_t st_r;
	logic [35:0] sh_r;
	logic [3:0] left_r;
	logic cmd_r;
	logic dat_r;
	logic stopw_r;
	logic [31:0] param_r;
	logic cfg_r;
	logic err_r;
	logic [3:0] rdnib_r;
	logic [3:0] devst_r;
	logic [1:0] hset_r;
	logic hcap_r;
	logic inx_r;
	logic [7:0] nib_r;
	logic [3:0] op;
	logic [3:0] np;
	logic refuse;
	logic full;
	logic wcmd;
	logic wdat;

	assign op = i_wdata[3:0];
	assign np = vpcs_pkg::vpcs_nparam(op);
	assign wcmd = i_ce && i_wr && i_addr == vpcs_pkg::HR_CMD &&
		st_r == H_IDLE;
	assign wdat = i_ce && i_wr && i_addr == vpcs_pkg::HR_DATA &&
		st_r == H_IDLE;
	assign full = nib_r >= (cfg_r ? vpcs_pkg::USR_DIRECT_NIB :
		vpcs_pkg::USR_FLEX_NIB);
	assign refuse = (op == vpcs_pkg::OP_PHRASE && hcap_r &&
		hset_r == vpcs_pkg::SET_FLEX && param_r[7:0] == 8'h00) ||
		(op == vpcs_pkg::OP_XFER && hset_r[1]);

	////////////////////////////////////////////////////////////////////
	// bus sequencing
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r <= H_IDLE;
			sh_r <= '0;
			left_r <= '0;
			cmd_r <= 1'b0;
			dat_r <= 1'b0;
			stopw_r <= 1'b0;
			rdnib_r <= '0;
			devst_r <= '0;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			bus.sel <= 1'b0;
			bus.hd <= '0;
			bus.hd_oe <= 1'b0;
		end else if (i_ce) begin
			unique case (st_r)
				H_IDLE: begin
					if (wcmd && !refuse) begin
						// parameters leave most significant nibble first
						sh_r <= {op, param_r << (6'd32 - {np, 2'b00})};
						left_r <= np + 4'h1;
						cmd_r <= 1'b1;
						stopw_r <= op == vpcs_pkg::OP_STOP;
						st_r <= H_SEND;
					end else if (wdat && inx_r && !full) begin
						sh_r <= {i_wdata[3:0], 32'h0000_0000};
						left_r <= 4'h1;
						cmd_r <= 1'b0;
						stopw_r <= 1'b0;
						st_r <= i_wdata[vpcs_pkg::HD_READ_BIT] ? H_DRD : H_SEND;
					end
				end
				H_SEND: begin
					bus.wr <= 1'b1;
					bus.sel <= cmd_r;
					bus.hd <= sh_r[35:32];
					bus.hd_oe <= 1'b1;
					sh_r <= {sh_r[31:0], 4'h0};
					left_r <= left_r - 4'h1;
					st_r <= H_POLL;
				end
				H_DRD: begin
					bus.rd <= 1'b1;
					bus.sel <= 1'b0;
					left_r <= '0;
					dat_r <= 1'b1;
					st_r <= H_GAP;
				end
				H_POLL: begin
					bus.wr <= 1'b0;
					bus.hd_oe <= 1'b0;
					bus.rd <= 1'b1;
					bus.sel <= 1'b1;
					st_r <= H_GAP;
				end
				H_GAP: begin
					bus.rd <= 1'b0;
					st_r <= H_LOOK;
				end
				H_LOOK: begin
					if (dat_r) begin
						rdnib_r <= bus.dd;
						dat_r <= 1'b0;
						st_r <= H_POLL;
					end else begin
						devst_r <= bus.dd;
						if (bus.dd[vpcs_pkg::ST_BUSY]) begin
							st_r <= H_POLL;
						end else if (stopw_r && bus.dd[vpcs_pkg::ST_ACTIVE]) begin
							st_r <= H_POLL;
						end else if (left_r != 4'h0) begin
							st_r <= H_SEND;
						end else begin
							st_r <= H_IDLE;
						end
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// software registers and tracking of the device mode
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			param_r <= '0;
			cfg_r <= 1'b0;
			err_r <= 1'b0;
			hset_r <= vpcs_pkg::RST_SET;
			hcap_r <= 1'b0;
			inx_r <= 1'b0;
			nib_r <= '0;
			o_rdata <= '0;
		end else if (i_ce) begin
			if (i_wr && i_addr == vpcs_pkg::HR_PARAM) begin
				param_r <= i_wdata;
			end
			if (i_wr && i_addr == vpcs_pkg::HR_CFG) begin
				cfg_r <= i_wdata[0];
			end
			if ((wcmd && refuse) || (wdat && (!inx_r || full))) begin
				err_r <= 1'b1;
			end else if (i_wr && i_addr == vpcs_pkg::HR_STAT) begin
				err_r <= 1'b0;
			end
			if (wcmd && !refuse) begin
				unique case (op)
					vpcs_pkg::OP_RATE: hset_r <= param_r[1:0];
					vpcs_pkg::OP_CAPTURE: hcap_r <= 1'b1;
					vpcs_pkg::OP_PLAY: hcap_r <= 1'b0;
					vpcs_pkg::OP_XFER: begin
						inx_r <= 1'b1;
						nib_r <= '0;
					end
					vpcs_pkg::OP_STOP: inx_r <= 1'b0;
					default: ;
				endcase
			end else if (wdat && inx_r && !full) begin
				nib_r <= nib_r + 8'h01;
			end
			if (i_rd) begin
				unique case (i_addr)
					vpcs_pkg::HR_PARAM: o_rdata <= param_r;
					vpcs_pkg::HR_DATA: o_rdata <= {28'h000_0000, rdnib_r};
					vpcs_pkg::HR_STAT: o_rdata <= {16'h0000, nib_r, 1'b0,
						inx_r, err_r, st_r == H_IDLE, devst_r};
					vpcs_pkg::HR_CFG: o_rdata <= {31'h0000_0000, cfg_r};
					default: o_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// file: dv/vpcs_properties.sv
// assertions on the nibble link between host and device ends
`timescale 1ns/1ps
module vpcs_properties (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic wr,
	input wire logic rd,
	input wire logic sel,
	input wire logic [3:0] hd,
	input wire logic hd_oe,
	input wire logic [3:0] dd,
	input wire logic dd_oe
);
	// cycles since the last write strobe, saturating
	logic [7:0] gap_r;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			gap_r <= 8'hff;
		else if (wr)
			gap_r <= 8'h00;
		else if (gap_r != 8'hff)
			gap_r <= gap_r + 8'h01;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	////////////////////////////////////////////////////////////////////
	property p_rd_answer; rd |=> dd_oe; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("no answer after read strobe");
	property p_no_spur; !rd |=> !dd_oe; endproperty
	a_no_spur: assert property (p_no_spur)
		else $error("answer without read strobe");
	property p_dd_hold; !$past(rd) |-> $stable(dd); endproperty
	a_dd_hold: assert property (p_dd_hold)
		else $error("answer nibble changed without read");
	property p_oe_excl; !(hd_oe && dd_oe); endproperty
	a_oe_excl: assert property (p_oe_excl)
		else $error("both ends drive the data nibble");
	property p_hd_oe_wr; hd_oe == wr; endproperty
	a_hd_oe_wr: assert property (p_hd_oe_wr)
		else $error("host drive enable not with write strobe");
	property p_wr_gap; wr |-> gap_r >= 8'h1e; endproperty
	a_wr_gap: assert property (p_wr_gap)
		else $error("write strobe inside busy time");
	property p_busy;
		dd_oe && $past(sel) && gap_r < 8'h1e |-> dd[3];
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy not shown after accepted nibble");
	property p_pause_active;
		dd_oe && $past(sel) && dd[2] |-> dd[0];
	endproperty
	a_pause_active: assert property (p_pause_active)
		else $error("paused without operation active");
endmodule

// file: dv/vpcs_tb_top.sv
// self-checking bench joining host and device ends of the nibble link
`timescale 1ns/1ps
module vpcs_tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic swr = 1'b0;
	logic srd = 1'b0;
	logic rom_valid = 1'b0;
	logic ce = 1'b1;
	logic voice = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [34:0] rom_rec = 35'h0;
	logic [31:0] rdata, stat;
	logic rom_req, mem_step, capture, width4, w;
	logic [7:0] rom_phrase, last_phrase, p, q, ey;
	logic [19:0] mem_addr, first_addr;
	logic [11:0] sx;
	logic [3:0] st;
	logic [3:0] nib [176];
	logic [1:0] volume;
	int n_errors = 0;
	int comparisons = 0;
	int nstep = 0;
	int n;
	vpcs_if bus_if();
	vpcs_host u_vpcs_host (.i_clk(clk), .i_nrst(nrst), .i_ce(ce),
		.bus(bus_if), .i_addr(addr), .i_wdata(wdata), .i_wr(swr),
		.i_rd(srd), .o_rdata(rdata));
	vpcs_dev #(.STEP_DIV0(8), .STEP_DIV1(8), .STEP_DIV2(8), .STEP_DIV3(8))
		u_vpcs_dev (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .bus(bus_if),
		.i_voice(voice), .i_rom_valid(rom_valid), .i_rom_rec(rom_rec),
		.o_rom_req(rom_req), .o_rom_phrase(rom_phrase),
		.o_mem_addr(mem_addr), .o_mem_step(mem_step), .o_capture(capture),
		.o_width4(width4), .o_volume(volume));
	vpcs_properties u_vpcs_properties (.i_clk(clk), .i_nrst(nrst),
		.wr(bus_if.wr), .rd(bus_if.rd), .sel(bus_if.sel), .hd(bus_if.hd),
		.hd_oe(bus_if.hd_oe), .dd(bus_if.dd), .dd_oe(bus_if.dd_oe));
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////
	// voice rom answers one cycle after each request; step monitor
	always @(posedge clk) begin
		rom_valid <= rom_req;
		if (rom_req)
			last_phrase <= rom_phrase;
		// a step pulse held by a frozen enable counts once, on release
		if (mem_step && ce && nstep == 0)
			first_addr <= mem_addr;
		if (mem_step && ce)
			nstep <= nstep + 1;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one software access; read data is valid at the following negedge
	task automatic sw(logic [4:0] a, logic [31:0] d, logic r);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		swr <= !r;
		srd <= r;
		@(posedge clk);
		swr <= 1'b0;
		srd <= 1'b0;
		@(negedge clk);
	endtask
	task automatic send(logic [4:0] a, logic [31:0] d);
		int i;
		sw(a, d, 1'b0);
		for (i = 0; i < 3000; i++) begin
			sw(vpcs_pkg::HR_STAT, 32'h0, 1'b1);
			stat = rdata;
			if (stat[4] === 1'b1)
				break;
		end
		if (i == 3000) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task automatic cmd(logic [3:0] op, logic [31:0] prm);
		send(vpcs_pkg::HR_PARAM, prm);
		send(vpcs_pkg::HR_CMD, {28'h0, op});
	endtask
	// a volume command refreshes the device status copy
	task automatic get_st();
		logic [1:0] v;
		v = 2'($urandom_range(3));
		cmd(vpcs_pkg::OP_VOLUME, 32'(v));
		st = stat[3:0];
		chk("volume", 32'(v), volume);
	endtask
	task automatic wait_end();
		int i;
		for (i = 0; i < 300; i++) begin
			get_st();
			if (st[0] === 1'b0)
				break;
		end
		if (i == 300) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h32a0));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		sw(vpcs_pkg::HR_STAT, 32'h0, 1'b1);
		chk("reset stat", 32'h10, rdata);
		sw(5'h14, 32'h0, 1'b1);
		chk("unmapped", 32'h0, rdata);
		cmd(vpcs_pkg::OP_PAUSE, 32'h0);
		get_st();
		chk("idle pause", 32'h0, st & 4'h5);
		$display("test reset done");
		for (int k = 2; k < 4; k++) begin
			p = (k == 3) ? 8'h3f : 8'($urandom_range(63));
			sx = 12'($urandom_range(4094));
			ey = 8'($urandom_range(15, 1));
			w = 1'($urandom);
			cmd(vpcs_pkg::OP_CODING, {29'h0, 2'h3, w});
			cmd(vpcs_pkg::OP_RATE, {28'h0, 2'($urandom), 2'(k)});
			cmd(vpcs_pkg::OP_PHRASE, {24'h0, p});
			cmd(vpcs_pkg::OP_ADDR, {sx, sx, ey});
			cmd(vpcs_pkg::OP_PLAY, 32'h0);
			chk("play dir", 32'h0, capture);
			nstep <= 0;
			cmd(vpcs_pkg::OP_START, 32'h0);
			wait_end();
			chk("steps", 32'(ey), nstep);
			chk("first addr", {12'h0, sx, 8'h0}, first_addr);
			chk("width", 32'(w), width4);
		end
		$display("test direct done");
		sx = 12'($urandom_range(4094));
		cmd(vpcs_pkg::OP_ADDR, {sx, sx + 12'h1, 8'h0});
		cmd(vpcs_pkg::OP_START, 32'h0);
		cmd(vpcs_pkg::OP_PAUSE, 32'h0);
		get_st();
		chk("paused", 32'h5, st & 4'h5);
		n = nstep;
		repeat (100) @(posedge clk);
		chk("held", n, nstep);
		cmd(vpcs_pkg::OP_PAUSE, 32'h0);
		get_st();
		chk("pause twice", 32'h5, st & 4'h5);
		cmd(vpcs_pkg::OP_START, 32'h0);
		get_st();
		chk("resumed", 32'h1, st & 4'h5);
		chk("moving", 32'h1, 32'(nstep > n));
		// enable low must freeze the step pacing mid-phrase
		@(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		n = nstep;
		repeat (50) @(posedge clk);
		chk("frozen", n, nstep);
		ce <= 1'b1;
		cmd(vpcs_pkg::OP_PAUSE, 32'h0);
		cmd(vpcs_pkg::OP_STOP, 32'h0);
		get_st();
		chk("stopped", 32'h0, st & 4'h5);
		$display("test pause done");
		cmd(vpcs_pkg::OP_CAPTURE, 32'h0);
		n = nstep;
		cmd(vpcs_pkg::OP_START, 32'h0);
		cmd(vpcs_pkg::OP_PAUSE, 32'h0);
		get_st();
		chk("trig wait", 32'h1, st & 4'h5);
		chk("no voice", n, nstep);
		@(posedge clk);
		voice <= 1'b1;
		cmd(vpcs_pkg::OP_PAUSE, 32'h0);
		@(posedge clk);
		voice <= 1'b0;
		n = nstep;
		cmd(vpcs_pkg::OP_START, 32'h0);
		get_st();
		chk("silent resume", 32'h1, 32'(nstep > n));
		cmd(vpcs_pkg::OP_STOP, 32'h0);
		cmd(vpcs_pkg::OP_PLAY, 32'h0);
		$display("test trigger done");
		cmd(vpcs_pkg::OP_RATE, {28'h0, 2'($urandom), 2'h1});
		p = 8'($urandom_range(255, 1));
		q = 8'($urandom_range(255, 1));
		w = 1'($urandom);
		@(posedge clk);
		rom_rec <= {sx, sx + 12'h1, 8'h0, 2'($urandom), w};
		cmd(vpcs_pkg::OP_PHRASE, {24'h0, p});
		cmd(vpcs_pkg::OP_START, 32'h0);
		chk("rom phrase", 32'(p), last_phrase);
		chk("rom width", 32'(w), width4);
		get_st();
		chk("next open", 32'h3, st & 4'h3);
		cmd(vpcs_pkg::OP_PHRASE, {24'h0, q});
		cmd(vpcs_pkg::OP_START, 32'h0);
		get_st();
		chk("next taken", 32'h1, st & 4'h3);
		wait_end();
		chk("queued", 32'(q), last_phrase);
		$display("test rom done");
		cmd(vpcs_pkg::OP_RATE, 32'h2);
		cmd(vpcs_pkg::OP_XFER, 32'h0);
		chk("xfer refused", 32'h1, stat[5]);
		// the error flag is sticky until software clears it
		sw(vpcs_pkg::HR_STAT, 32'h0, 1'b0);
		cmd(vpcs_pkg::OP_RATE, 32'h0);
		p = 8'($urandom_range(63, 1));
		cmd(vpcs_pkg::OP_XFER, 32'h0);
		cmd(vpcs_pkg::OP_PHRASE, {24'h0, p});
		cmd(vpcs_pkg::OP_CAPTURE, 32'h0);
		chk("capture", 32'h1, capture);
		send(vpcs_pkg::HR_DATA, 32'h100);
		sw(vpcs_pkg::HR_DATA, 32'h0, 1'b1);
		chk("status read", 32'h0, rdata[3:0]);
		// the status read above uses one of the 176 host slots
		for (int i = 0; i < 175; i++) begin
			nib[i] = 4'($urandom);
			send(vpcs_pkg::HR_DATA, {28'h0, nib[i]});
		end
		chk("in capacity", 32'h0, stat[5]);
		send(vpcs_pkg::HR_DATA, 32'h0);
		chk("over capacity", 32'h1, stat[5]);
		cmd(vpcs_pkg::OP_STOP, 32'h0);
		cmd(vpcs_pkg::OP_XFER, 32'h0);
		cmd(vpcs_pkg::OP_PHRASE, {24'h0, p});
		cmd(vpcs_pkg::OP_PLAY, 32'h0);
		for (int i = 0; i < 175; i++) begin
			send(vpcs_pkg::HR_DATA, 32'h100);
			sw(vpcs_pkg::HR_DATA, 32'h0, 1'b1);
			chk("user nibble", 32'(nib[i]), rdata[3:0]);
		end
		cmd(vpcs_pkg::OP_STOP, 32'h0);
		$display("test transfer done");
		report_and_stop();
	end
endmodule
